// *** inc/msc_map.svh ***
// register offsets, field positions, reset values and counts of the port
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH

// ----------------------------------------------------------------------
// interface control register
// ----------------------------------------------------------------------
`define MSC_CTRL_OFS    8'h06
`define MSC_CTRL_RST    16'h0200
`define MSC_B_CSMODE    1
`define MSC_B_SEPOUT    2
`define MSC_B_ODRAIN    3
`define MSC_B_STEP      9

// ----------------------------------------------------------------------
// serial framing
// ----------------------------------------------------------------------
`define MSC_DEV_ID      7'h1a
`define MSC_WORD_BITS   5'h18
`define MSC_ADDR_END    5'h07
`define MSC_DATA_START  5'h08
`define MSC_CNT_MAX     5'h1f
`define MSC_RW_BIT      23

// ----------------------------------------------------------------------
// input synchroniser lanes
// ----------------------------------------------------------------------
`define MSC_SYNC_W      9
`define MSC_SYNC_INIT   9'h01f

`endif

// *** inc/msc_pkg.sv ***
// types of the serial control port
package msc_pkg;

   // two-wire protocol states, one-hot
   typedef enum logic [8:0] {
      st_idle     = 9'h001,
      st_id       = 9'h002,
      st_id_ack   = 9'h004,
      st_addr     = 9'h008,
      st_addr_ack = 9'h010,
      st_wr       = 9'h020,
      st_wr_ack   = 9'h040,
      st_rd       = 9'h080,
      st_rd_ack   = 9'h100
   } msc_state_e;

endpackage

// *** inc/msc_sync_if.sv ***
// carrier between the port and its input synchroniser
`timescale 1ns/1ps
interface msc_sync_if #(parameter int W = 9);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// *** rtl/msc_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module msc_sync #(
   parameter int             W    = 9,
   parameter logic [W-1:0]   INIT = '0
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // raw levels in, filtered levels out
   msc_sync_if.sync  sif
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] held;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
      end else begin
         s1 <= sif.raw;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a lane changes only where stages two and three agree
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         held <= INIT;
      end else begin
         held <= (s2 & s3) | (held & (s2 | s3));
      end
   end

   assign sif.clean = held;
endmodule

// *** rtl/msc_port.sv ***
// multi-mode serial control port: 2-wire, 3-wire and 4-wire register access
`timescale 1ns/1ps
`include "msc_map.svh"
module msc_port #(
   parameter logic [6:0] DEV_ID     = `MSC_DEV_ID,
   parameter logic [6:0] SEC_DEV_ID = `MSC_DEV_ID,
   parameter bit         WRITE_ONLY = 1'b0
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // serial clock, also the link clock
   input  wire logic        control_clock_pin,
   // bidirectional data pin
   input  wire logic        control_data_pin_i,
   output wire logic        control_data_pin_o,
   output logic             control_data_pin_oe,
   // general pins
   output logic             general_pin_six_o,
   output logic             general_pin_six_oe,
   input  wire logic        general_pin_seven,
   input  wire logic        general_pin_ten,
   input  wire logic        general_pin_eleven_i,
   output wire logic        general_pin_eleven_o,
   output logic             general_pin_eleven_oe,
   // mode strap
   input  wire logic        development_mode,
   // register port
   output logic [7:0]       reg_addr,
   output logic [15:0]      reg_wdata,
   output logic             reg_wr,
   input  wire logic [15:0] reg_rdata,
   // interface control register contents
   output wire logic [15:0] serial_port_control
);
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic is_ctrl(input logic [7:0] a);
      return a == `MSC_CTRL_OFS;
   endfunction

   function automatic logic [15:0] rd_word(input logic [7:0]  a,
                                           input logic [15:0] c,
                                           input logic [15:0] ext);
      return is_ctrl(a) ? c : ext;
   endfunction

   logic [15:0]        ctl;
   logic [15:0]        rd_hold;
   logic [23:0]        lk_sr;
   logic [4:0]         lk_cnt;
   logic               lk_rw;
   logic               lk_live;
   logic               lk_req;
   logic               lk_dout;
   logic               lk_drv;
   logic [6:0]         lk_addr;
   logic               lk_din;
   logic [3:0]         lk_idx;

   // open-drain pins only ever pull low
   assign control_data_pin_o   = 1'b0;
   assign general_pin_eleven_o = 1'b0;
   assign serial_port_control  = ctl;

   // ------------------------------------------------------------------
   // link domain: chip-select word shifter
   // ------------------------------------------------------------------
   assign lk_din = (lk_rw && lk_live && lk_cnt >= `MSC_DATA_START) ?
                   1'b0 : control_data_pin_i;
   assign lk_idx = 4'(`MSC_WORD_BITS - 5'h01 - lk_cnt);

   // frame flag: cleared while chip select is high
   always_ff @(posedge control_clock_pin or posedge reset
               or posedge general_pin_seven) begin
      if (reset || general_pin_seven) begin
         lk_live <= 1'b0;
      end else begin
         lk_live <= 1'b1;
      end
   end

   always_ff @(posedge control_clock_pin or posedge reset) begin
      if (reset) begin
         lk_sr   <= '0;
         lk_cnt  <= '0;
         lk_rw   <= 1'b0;
         lk_addr <= '0;
         lk_req  <= 1'b0;
      end else begin
         lk_sr <= {lk_sr[22:0], lk_din};
         if (!lk_live) begin
            lk_cnt <= 5'h01;
            lk_rw  <= control_data_pin_i;
         end else if (lk_cnt != `MSC_CNT_MAX) begin
            lk_cnt <= lk_cnt + 5'h01;
         end
         if (lk_live && lk_cnt == `MSC_ADDR_END) begin
            lk_addr <= {lk_sr[5:0], lk_din};
            if (lk_rw) begin
               lk_req <= ~lk_req;
            end
         end
      end
   end

   // read data leaves on the falling clock edge
   always_ff @(negedge control_clock_pin or posedge reset
               or posedge general_pin_seven) begin
      if (reset || general_pin_seven) begin
         lk_dout <= 1'b0;
         lk_drv  <= 1'b0;
      end else begin
         lk_drv  <= lk_live && lk_rw && lk_cnt >= `MSC_DATA_START
                    && lk_cnt < `MSC_WORD_BITS;
         lk_dout <= rd_hold[lk_idx];
      end
   end

   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   msc_sync_if #(.W(`MSC_SYNC_W)) sif ();

   assign sif.raw = {development_mode, lk_drv, lk_dout, lk_req,
                     general_pin_seven, general_pin_eleven_i,
                     general_pin_ten, control_data_pin_i,
                     control_clock_pin};

   msc_sync #(
      .W    (`MSC_SYNC_W),
      .INIT (`MSC_SYNC_INIT)
   ) u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .sif     (sif)
   );

   logic               sec;
   logic               scl;
   logic               sda;
   logic               scl_p;
   logic               sda_p;
   logic               cs_p;
   logic               req_p;
   logic               i2c_en;
   logic               four;
   logic               spi3;
   logic               scl_rise;
   logic               scl_fall;
   logic               start_c;
   logic               stop_c;
   logic               last_bit;
   logic [7:0]         byte_in;
   logic [6:0]         my_id;
   logic [15:0]        rd_now;

   assign sec    = sif.clean[8];
   assign scl    = sec ? sif.clean[2] : sif.clean[0];
   assign sda    = sec ? sif.clean[3] : sif.clean[1];
   assign my_id  = sec ? SEC_DEV_ID : DEV_ID;
   assign four   = ctl[`MSC_B_CSMODE] && ctl[`MSC_B_SEPOUT] && !sec;
   assign spi3   = ctl[`MSC_B_CSMODE] && !ctl[`MSC_B_SEPOUT] && !sec;

   // ------------------------------------------------------------------
   // two-wire engine
   // ------------------------------------------------------------------
   msc_pkg::msc_state_e st;
   logic [2:0]         bcnt;
   logic [6:0]         isr;
   logic               lo;
   logic               irw;
   logic               i2c_drv;
   logic               addr_rx;
   logic               wr_hi;
   logic               wr_commit;
   logic               rd_step;

   // the engine runs a transfer in flight to its end; 4-wire mode still releases its data pin at once
   assign i2c_en = sec || !ctl[`MSC_B_CSMODE]
                   || st != msc_pkg::st_idle;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
         cs_p  <= 1'b1;
         req_p <= 1'b0;
      end else begin
         scl_p <= scl;
         sda_p <= sda;
         cs_p  <= sif.clean[4];
         req_p <= sif.clean[5];
      end
   end

   assign scl_rise  = scl && !scl_p;
   assign scl_fall  = !scl && scl_p;
   assign start_c   = scl && scl_p && !sda && sda_p;
   assign stop_c    = scl && scl_p && sda && !sda_p;
   assign byte_in   = {isr, sda};
   assign last_bit  = scl_rise && bcnt == 3'h7;
   assign addr_rx   = st == msc_pkg::st_addr && last_bit;
   assign wr_hi     = st == msc_pkg::st_wr && last_bit && !lo;
   assign wr_commit = st == msc_pkg::st_wr && last_bit && lo;
   assign rd_step   = st == msc_pkg::st_rd_ack && scl_rise && !sda && lo
                      && ctl[`MSC_B_STEP];
   assign rd_now    = rd_word(reg_addr, ctl, reg_rdata);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st   <= msc_pkg::st_idle;
         bcnt <= '0;
         isr  <= '0;
         lo   <= 1'b0;
         irw  <= 1'b0;
      end else if (!i2c_en || stop_c) begin
         st <= msc_pkg::st_idle;
      end else if (start_c) begin
         st   <= msc_pkg::st_id;
         bcnt <= '0;
      end else if (scl_rise) begin
         isr  <= byte_in[6:0];
         bcnt <= bcnt + 3'h1;
         unique case (st)
            msc_pkg::st_idle: st <= msc_pkg::st_idle;
            msc_pkg::st_id: if (bcnt == 3'h7) begin
               irw <= byte_in[0];
               if (byte_in[7:1] != my_id || (byte_in[0] && WRITE_ONLY))
                  st <= msc_pkg::st_idle;
               else
                  st <= msc_pkg::st_id_ack;
            end
            msc_pkg::st_id_ack: begin
               bcnt <= '0;
               lo   <= 1'b0;
               st   <= irw ? msc_pkg::st_rd : msc_pkg::st_addr;
            end
            msc_pkg::st_addr: if (bcnt == 3'h7) begin
               st <= msc_pkg::st_addr_ack;
            end
            msc_pkg::st_addr_ack: begin
               bcnt <= '0;
               lo   <= 1'b0;
               st   <= msc_pkg::st_wr;
            end
            msc_pkg::st_wr: if (bcnt == 3'h7) begin
               st <= msc_pkg::st_wr_ack;
            end
            msc_pkg::st_wr_ack: begin
               bcnt <= '0;
               lo   <= ~lo;
               st   <= msc_pkg::st_wr;
            end
            msc_pkg::st_rd: if (bcnt == 3'h7) begin
               st <= msc_pkg::st_rd_ack;
            end
            msc_pkg::st_rd_ack: begin
               bcnt <= '0;
               lo   <= ~lo;
               st   <= sda ? msc_pkg::st_idle : msc_pkg::st_rd;
            end
            default: st <= msc_pkg::st_idle;
         endcase
      end
   end

   // data pin drive changes while the clock is low
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         i2c_drv <= 1'b0;
      end else if (!i2c_en || start_c || stop_c) begin
         i2c_drv <= 1'b0;
      end else if (scl_fall) begin
         if (st == msc_pkg::st_id_ack || st == msc_pkg::st_addr_ack
             || st == msc_pkg::st_wr_ack)
            i2c_drv <= 1'b1;
         else if (st == msc_pkg::st_rd)
            i2c_drv <= !rd_now[{!lo, 3'(3'h7 - bcnt)}];
         else
            i2c_drv <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // register access
   // ------------------------------------------------------------------
   logic [7:0]         hi_b;
   logic               step_pend;
   logic               rd_pend;
   logic               spi_commit;
   logic               spi_req;
   logic [7:0]         spi_addr;

   // shifter is quiet once chip select is high, so its word is stable
   assign spi_commit = sif.clean[4] && !cs_p && ctl[`MSC_B_CSMODE] && !sec
                       && lk_cnt >= `MSC_WORD_BITS
                       && !lk_sr[`MSC_RW_BIT];
   assign spi_req    = sif.clean[5] != req_p && ctl[`MSC_B_CSMODE] && !sec;
   assign spi_addr   = {1'b0, lk_sr[22:16]};

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_addr  <= '0;
         reg_wdata <= '0;
         reg_wr    <= 1'b0;
         ctl       <= `MSC_CTRL_RST;
         hi_b      <= '0;
         step_pend <= 1'b0;
         rd_pend   <= 1'b0;
         rd_hold   <= '0;
      end else begin
         reg_wr    <= 1'b0;
         step_pend <= 1'b0;
         rd_pend   <= 1'b0;
         if (rd_pend)
            rd_hold <= rd_now;
         if (step_pend || rd_step)
            reg_addr <= reg_addr + 8'h01;
         if (addr_rx)
            reg_addr <= byte_in;
         if (wr_hi)
            hi_b <= byte_in;
         if (wr_commit) begin
            reg_wdata <= {hi_b, byte_in};
            if (is_ctrl(reg_addr))
               ctl <= {hi_b, byte_in};
            else
               reg_wr <= 1'b1;
            step_pend <= ctl[`MSC_B_STEP];
         end
         if (spi_commit) begin
            reg_addr  <= spi_addr;
            reg_wdata <= lk_sr[15:0];
            if (is_ctrl(spi_addr))
               ctl <= lk_sr[15:0];
            else
               reg_wr <= 1'b1;
         end
         if (spi_req) begin
            reg_addr <= {1'b0, lk_addr};
            rd_pend  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         control_data_pin_oe   <= 1'b0;
         general_pin_eleven_oe <= 1'b0;
         general_pin_six_o     <= 1'b0;
         general_pin_six_oe    <= 1'b0;
      end else begin
         control_data_pin_oe <= (i2c_drv && !sec && !four)
            || (spi3 && sif.clean[7] && !sif.clean[6]);
         general_pin_eleven_oe <= i2c_drv && sec;
         if (!four) begin
            general_pin_six_o  <= 1'b0;
            general_pin_six_oe <= 1'b0;
         end else if (ctl[`MSC_B_ODRAIN]) begin
            general_pin_six_o  <= 1'b0;
            general_pin_six_oe <= sif.clean[7] && !sif.clean[6];
         end else begin
            general_pin_six_o  <= sif.clean[7] && sif.clean[6];
            general_pin_six_oe <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   property p_cs_mode_idle;
      !i2c_en |=> st == msc_pkg::st_idle;
   endproperty
   a_cs_mode_idle: assert property (p_cs_mode_idle) else
      $error("two-wire engine active in chip-select mode");

   property p_pin_six_free;
      !four |=> !general_pin_six_oe;
   endproperty
   a_pin_six_free: assert property (p_pin_six_free) else
      $error("pin six driven outside 4-wire mode");

   property p_od_idle;
      four && ctl[`MSC_B_ODRAIN] && !sif.clean[7] |=> !general_pin_six_oe;
   endproperty
   a_od_idle: assert property (p_od_idle) else
      $error("open-drain readback driven while idle");

   property p_pp_idle;
      four && !ctl[`MSC_B_ODRAIN] && !sif.clean[7]
         |=> general_pin_six_oe && !general_pin_six_o;
   endproperty
   a_pp_idle: assert property (p_pp_idle) else
      $error("push-pull readback not low while idle");

   property p_four_no_data;
      ctl[`MSC_B_CSMODE] && ctl[`MSC_B_SEPOUT] |=> !control_data_pin_oe;
   endproperty
   a_four_no_data: assert property (p_four_no_data) else
      $error("data pin driven in 4-wire mode");

   property p_start;
      i2c_en && start_c |=> st == msc_pkg::st_id && bcnt == 3'h0;
   endproperty
   a_start: assert property (p_start) else
      $error("start condition not taken");

   property p_ack;
      i2c_en && st == msc_pkg::st_id_ack && scl_fall |=> i2c_drv;
   endproperty
   a_ack: assert property (p_ack) else
      $error("matching identifier not acknowledged");

   property p_mismatch;
      i2c_en && st == msc_pkg::st_id && last_bit && byte_in[7:1] != my_id
         |=> st == msc_pkg::st_idle;
   endproperty
   a_mismatch: assert property (p_mismatch) else
      $error("foreign identifier not ignored");

   property p_stop;
      stop_c |=> st == msc_pkg::st_idle && !i2c_drv;
   endproperty
   a_stop: assert property (p_stop) else
      $error("stop did not return to idle");

   property p_no_step;
      wr_commit && !ctl[`MSC_B_STEP] |-> ##2 reg_addr == $past(reg_addr, 2);
   endproperty
   a_no_step: assert property (p_no_step) else
      $error("address moved with stepping off");

   property p_step;
      wr_commit && ctl[`MSC_B_STEP]
         |-> ##2 reg_addr == $past(reg_addr, 2) + 8'h01;
   endproperty
   a_step: assert property (p_step) else
      $error("address did not step after write");

   property p_spi_ctrl;
      spi_commit && is_ctrl(spi_addr) |=> ctl == $past(lk_sr[15:0]);
   endproperty
   a_spi_ctrl: assert property (p_spi_ctrl) else
      $error("chip-select write to control register lost");
endmodule

// *** verification/msc_host.sv ***
// host master model for the serial control pins
`timescale 1ns/1ps
module msc_host (
   // pins
   output logic      scl,
   output logic      sda_low,
   output logic      cs_n,
   input  wire logic sda,
   input  wire logic sdo
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      cs_n = 1'b1;
   end
   task automatic start();
      #20 sda_low = 1'b0;
      #60 scl = 1'b1;
      #80 sda_low = 1'b1;
      #80 scl = 1'b0;
   endtask
   task automatic stop();
      #20 sda_low = 1'b1;
      #60 scl = 1'b1;
      #80 sda_low = 1'b0;
      #160;
   endtask
   // one byte plus acknowledge bit; data moves only while clock low
   task automatic xfer(input logic [7:0] b, input logic m_ack,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #20 sda_low = ~b[i];
         #60 scl = 1'b1;
         rx[i] = sda;
         #80 scl = 1'b0;
      end
      #20 sda_low = m_ack;
      #60 scl = 1'b1;
      ack = ~sda;
      #80 scl = 1'b0;
   endtask
   // 24-bit word; 4-wire read toggles the data pin to prove it unused
   task automatic spi(input logic [23:0] w, input logic four,
                      output logic [15:0] rx);
      cs_n = 1'b0;
      #80;
      for (int i = 23; i >= 0; i--) begin
         scl = 1'b0;
         sda_low = (i > 15 || !w[23]) ? ~w[i] : (four & i[0]);
         #80 scl = 1'b1;
         rx[i % 16] = four ? sdo : sda;
         #80;
      end
      #40 cs_n = 1'b1;
      sda_low = 1'b0;
      #200;
   endtask
endmodule

// *** verification/tb_top.sv ***
// self-checking bench of the serial control port
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys, reset, development_mode;
   logic        scl, sda_low, cs_n, sda, sdo, ack;
   logic        dat_oe, six_o, six_oe, reg_wr;
   logic        dat_o, sec_o, sec_oe;
   logic [7:0]  reg_addr, rx8, last_a;
   logic [15:0] reg_wdata, reg_rdata, ctl, rx16, last_d;
   int          miscompares, comparisons, wr_cnt;
   // open-drain lines with pull-ups
   assign sda = (dat_oe ? dat_o : 1'b1) & (sec_oe ? sec_o : 1'b1)
                & ~sda_low;
   assign sdo = six_oe ? six_o : 1'b1;
   assign reg_rdata = {reg_addr, ~reg_addr};
   msc_port u_msc_port (
      .clk_sys, .reset, .development_mode,
      .control_clock_pin(scl), .control_data_pin_i(sda),
      .control_data_pin_o(dat_o), .control_data_pin_oe(dat_oe),
      .general_pin_six_o(six_o), .general_pin_six_oe(six_oe),
      .general_pin_seven(cs_n), .general_pin_ten(scl),
      .general_pin_eleven_i(sda), .general_pin_eleven_o(sec_o),
      .general_pin_eleven_oe(sec_oe), .reg_addr, .reg_wdata, .reg_wr,
      .reg_rdata, .serial_port_control(ctl));
   msc_host u_msc_host (.scl, .sda_low, .cs_n, .sda, .sdo);
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (reg_wr === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
         last_a <= reg_addr;
         last_d <= reg_wdata;
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // 2-wire write of n words held msb first in d
   task automatic wr2(input logic [7:0] a, input logic [31:0] d,
                      input int n);
      u_msc_host.start();
      u_msc_host.xfer(8'h34, 1'b0, rx8, ack);
      chk("id ack", 16'h1, {15'h0, ack});
      u_msc_host.xfer(a, 1'b0, rx8, ack);
      chk("addr ack", 16'h1, {15'h0, ack});
      for (int j = 0; j < 2 * n; j++) begin
         u_msc_host.xfer(d[31-8*j -: 8], 1'b0, rx8, ack);
         chk("data ack", 16'h1, {15'h0, ack});
      end
      u_msc_host.stop();
   endtask
   task automatic rd2(input logic [7:0] a);
      u_msc_host.start();
      u_msc_host.xfer(8'h34, 1'b0, rx8, ack);
      u_msc_host.xfer(a, 1'b0, rx8, ack);
      u_msc_host.start();
      u_msc_host.xfer(8'h35, 1'b0, rx8, ack);
      chk("rd id ack", 16'h1, {15'h0, ack});
      u_msc_host.xfer(8'hff, 1'b1, rx16[15:8], ack);
      u_msc_host.xfer(8'hff, 1'b0, rx16[7:0], ack);
      u_msc_host.stop();
   endtask
   initial begin
      #400000;
      miscompares++;
      final_report();
   end
   initial begin
      reset = 1'b1;
      development_mode = 1'b0;
      miscompares = 0;
      comparisons = 0;
      wr_cnt = 0;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk("ctl reset", 16'h0200, ctl);
      wr2(8'h10, 32'h1234_5678, 2);
      chk("wr count", 16'h2, wr_cnt[15:0]);
      chk("wr addr", 16'h11, {8'h0, last_a});
      chk("wr data", 16'h5678, last_d);
      rd2(8'h20);
      chk("rd data", 16'h20df, rx16);
      u_msc_host.start();
      u_msc_host.xfer(8'h36, 1'b0, rx8, ack);
      chk("bad id ack", 16'h0, {15'h0, ack});
      u_msc_host.xfer(8'h50, 1'b0, rx8, ack);
      u_msc_host.stop();
      wr2(8'h06, 32'h0000_0000, 1);
      wr2(8'h40, 32'haaaa_bbbb, 2);
      chk("no step addr", 16'h40, {8'h0, last_a});
      wr2(8'h06, 32'h0202_0000, 1);
      chk("ctl 3w", 16'h0202, ctl);
      u_msc_host.spi({1'b0, 7'h15, 16'hbeef}, 1'b0, rx16);
      chk("3w data", 16'hbeef, last_d);
      chk("3w addr", 16'h15, {8'h0, last_a});
      u_msc_host.spi({1'b1, 7'h2a, 16'h0}, 1'b0, rx16);
      chk("3w read", 16'h2ad5, rx16);
      chk("six off", 16'h0, {15'h0, six_oe});
      for (int m = 0; m < 2; m++) begin
         u_msc_host.spi({8'h06, m ? 16'h020e : 16'h0206}, 1'b0,
                        rx16);
         chk("ctl 4w", m ? 16'h020e : 16'h0206, ctl);
         chk("idle oe", {15'h0, ~m[0]}, {15'h0, six_oe});
         chk("idle o", 16'h0, {15'h0, six_o & six_oe});
         u_msc_host.spi({8'hb1, 16'h0}, 1'b1, rx16);
         chk("4w read", 16'h31ce, rx16);
      end
      chk("wr total", 16'h5, wr_cnt[15:0]);
      @(posedge clk_sys);
      development_mode <= 1'b1;
      repeat (10) @(posedge clk_sys);
      wr2(8'h50, 32'h1357_0000, 1);
      chk("dev data", 16'h1357, last_d);
      chk("dev addr", 16'h50, {8'h0, last_a});
      chk("dev total", 16'h6, wr_cnt[15:0]);
      final_report();
   end
endmodule
